// File: src/mss_pkg.sv
// Package: register map, field layout, reset values and timing constants
package mss_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_CFG     = 12'h000;
  localparam logic [11:0] OFF_ILIM    = 12'h004;
  localparam logic [11:0] OFF_SETP    = 12'h008;
  localparam logic [11:0] OFF_SAFE_LO = 12'h00C;
  localparam logic [11:0] OFF_SAFE_HI = 12'h010;
  localparam logic [11:0] OFF_VLIM    = 12'h014;
  localparam logic [11:0] OFF_DWELL   = 12'h018;
  localparam logic [11:0] OFF_INDUCT  = 12'h01C;
  localparam logic [11:0] OFF_HTR_I   = 12'h020;
  localparam logic [11:0] OFF_AMPS    = 12'h024;
  localparam logic [11:0] OFF_TESLA   = 12'h028;
  localparam logic [11:0] OFF_CTRL    = 12'h02C;
  localparam logic [11:0] OFF_STAT    = 12'h030;
  localparam logic [11:0] OFF_CMD     = 12'h034;
  localparam logic [11:0] OFF_FIELD   = 12'h038;
  // Breakpoint table: 16 words from here
  localparam logic [11:0] OFF_BKPT    = 12'h040;
  // Rate tables: 4 x 16 words, table in addr[7:6], entry in addr[5:2]
  localparam logic [11:0] OFF_RATE    = 12'h100;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CFG_SWITCH  = 0;
  localparam int CFG_FILTER  = 1;
  localparam int CFG_BLANK   = 2;
  localparam int CFG_UNIPOL  = 3;
  localparam int CTRL_HREQ   = 0;
  localparam int CTRL_HEDIT  = 1;
  localparam int CTRL_FAST   = 2;
  localparam int CTRL_SWEEP  = 3;
  localparam int CTRL_CCLR   = 4;
  localparam int ST_CFG_REJ  = 0;
  localparam int ST_SETP_REJ = 1;
  localparam int ST_OVERLAP  = 2;
  localparam int ST_DWELL    = 3;
  localparam int ST_RANGE    = 4;
  localparam int ST_SAFE     = 8;
  localparam int ST_CATCH    = 9;
  localparam int ST_HEATER   = 10;
  localparam int ST_HWLIM    = 11;

  // Rate table selection
  localparam logic [1:0] TBL_LEAD_ZERO  = 2'h0;
  localparam logic [1:0] TBL_LEAD_FIELD = 2'h1;
  localparam logic [1:0] TBL_FAST       = 2'h2;
  localparam logic [1:0] TBL_SLOW       = 2'h3;

  // ---------------------------------------------------------------
  // Values (current in 10 mA, voltage in 10 mV, L in 0.1 H,
  // heater in 0.1 mA)
  // ---------------------------------------------------------------
  localparam logic [15:0] FULL_SCALE   = 16'h2EE0;
  localparam logic [15:0] VLIM_10V     = 16'h04E1;
  localparam logic [15:0] VLIM_20V     = 16'h09C3;
  localparam logic [7:0]  DWELL_OFF    = 8'hFF;
  localparam logic [7:0]  DWELL_MIN    = 8'h02;
  localparam logic [15:0] INDUCT_MAX   = 16'h4433;
  localparam logic [15:0] HTR_I_MAX    = 16'h04A7;
  localparam logic [7:0]  CFG_RESET    = 8'h00;
  localparam int          COMP_SHIFT   = 16;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int QUARTER_NS    = 250_000_000;
  localparam int QUARTER_CYC   = QUARTER_NS / CLK_PERIOD_NS;
  localparam int BLANK_MS      = 2000;
  localparam int QUARTER_MS    = 250;
  localparam logic [3:0] BLANK_QTRS = 4'(BLANK_MS / QUARTER_MS);

endpackage

// File: src/mss_supervisor.sv
// Magnet sweep supervisor: configuration, limits, rate tables, catch trip
//
// What this block does
// - Hold 8-bit configuration; reject illegal, keep old
// - Switch bit enables heater; else ignore requests
// - Filter compensation with switch bit is illegal
// - Add capacitor charge current at sweep changes
// - Blanking bit ignores first two seconds of hardware limiting
// - Unipolar bit forbids negative commanded current
// - Refuse set-point above current limit
// - Safe output only inside safe window
// - Reject lower safe above upper, flag overlap
// - Rate entry n covers breakpoints n-1..n
// - Four rate tables chosen by condition
// - One voltage limit applies to both polarities
// - Continuous overvoltage for dwell trips catch
// - Dwell in quarter seconds, below two rejected
// - Dwell of 255 disables the trip
// - Defaults: 12.49 or 24.99 V, dwell 255
// - Inductance 0.0 to 1745.9 H, default zero
// - Heater current 0 to 119.1 mA, heater on editing
// - Field from current by one linear constant
`timescale 1ns/1ns
`default_nettype none

module mss_supervisor #(
  parameter int QTR_CYC = mss_pkg::QUARTER_CYC,
  parameter bit HIGH_V  = 1'b0
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic [31:0]             prdata,
  // Measurements, same clock domain
  input  wire logic signed [15:0] meas_current,
  input  wire logic signed [15:0] out_voltage,
  // Pins
  input  wire logic               hw_vlimit,
  input  wire logic               magnet_at_field,
  // Supervisor outputs
  output logic signed [15:0]      cmd_current,
  output logic [15:0]             rate_limit,
  output logic                    safe_current,
  output logic                    catch_mode,
  output logic                    heater_on,
  output logic [15:0]             heater_current,
  output logic                    config_reject_indication,
  output logic                    safe_window_overlap_indication
);

  typedef struct packed {
    logic [7:0]               cfg;
    logic [15:0]              ilim;
    logic signed [15:0]       setp;
    logic signed [15:0]       safe_lo;
    logic signed [15:0]       safe_hi;
    logic [15:0]              vlim;
    logic [7:0]               dwell;
    logic [15:0]              induct;
    logic [15:0]              htr_i;
    logic [15:0]              amps;
    logic [15:0]              tesla;
    logic [3:0]               ctrl;
    logic [4:0]               flags;
    logic [15:0][15:0]        bkpt;
    logic [3:0][15:0][15:0]   rate;
    logic                     hw_s1;
    logic                     hw_s2;
    logic                     af_s1;
    logic                     af_s2;
    logic [25:0]              sw_pre;
    logic [7:0]               sw_qtr;
    logic [25:0]              hw_pre;
    logic [3:0]               hw_qtr;
    logic [25:0]              cmp_pre;
    logic                     catch;
    logic                     safe;
    logic                     heater;
    logic [15:0]              htr_out;
    logic [15:0]              rate_out;
    logic signed [32:0]       lrate_prev;
    logic signed [15:0]       comp;
    logic signed [15:0]       cmd;
    logic [5:0]               div_cnt;
    logic [31:0]              div_q;
    logic [16:0]              div_rem;
    logic [23:0]              k;
    logic signed [15:0]       field;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } mss_state_t;

  mss_state_t s;
  mss_state_t next_s;

  function automatic logic [16:0] mss_abs(input logic signed [15:0] v);
    logic signed [16:0] w;
    w = {v[15], v};
    return v[15] ? 17'(-w) : 17'(w);
  endfunction

  localparam logic [25:0] QTR_LAST = 26'(QTR_CYC - 1);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic        wr;
    logic        rd;
    logic [11:0] a;
    logic [15:0] wd;
    logic [4:0]  set_f;
    logic [3:0]  seg;
    logic [1:0]  tsel;
    logic [16:0] am;
    logic        sw_over;
    logic [15:0] rate_eff;
    logic signed [32:0] lrate;
    logic signed [32:0] dl;
    logic signed [16:0] cmd_w;
    logic [16:0] rs;
    logic signed [40:0] fp;
    next_s = s;
    wr = 1'b0;
    rd = 1'b0;
    a = paddr;
    wd = pwdata[15:0];
    set_f = 5'h00;
    seg = 4'hF;
    tsel = mss_pkg::TBL_LEAD_ZERO;
    am = mss_abs(meas_current);
    sw_over = 1'b0;
    rate_eff = 16'h0000;
    lrate = 33'sh0_0000_0000;
    dl = 33'sh0_0000_0000;
    cmd_w = 17'sh0_0000;
    rs = 17'h0_0000;
    fp = '0;

    // APB: one wait state, write lands with pready high
    wr = psel && penable && s.pready && pwrite;
    rd = psel && penable && !s.pready && !pwrite;
    next_s.pready = psel && penable && !s.pready;
    if (psel && penable && !s.pready) begin
      next_s.pslverr = !(a < 12'h03C || (a >= mss_pkg::OFF_BKPT && a < 12'h080)
                         || (a >= mss_pkg::OFF_RATE && a < 12'h200));
    end
    next_s.ctrl[0] = s.ctrl[0];

    // Input synchronisers
    next_s.hw_s1 = hw_vlimit;
    next_s.hw_s2 = s.hw_s1;
    next_s.af_s1 = magnet_at_field;
    next_s.af_s2 = s.af_s1;

    if (wr) begin
      unique case (a)
        mss_pkg::OFF_CFG: begin
          if (wd[mss_pkg::CFG_SWITCH] && wd[mss_pkg::CFG_FILTER]) begin
            set_f[mss_pkg::ST_CFG_REJ] = 1'b1;
          end else begin
            next_s.cfg = wd[7:0];
          end
        end
        mss_pkg::OFF_ILIM: begin
          if (wd > mss_pkg::FULL_SCALE) set_f[mss_pkg::ST_RANGE] = 1'b1;
          else next_s.ilim = wd;
        end
        mss_pkg::OFF_SETP: begin
          if (mss_abs(wd) > {1'b0, s.ilim}
              || (s.cfg[mss_pkg::CFG_UNIPOL] && wd[15])) begin
            set_f[mss_pkg::ST_SETP_REJ] = 1'b1;
          end else begin
            next_s.setp = wd;
          end
        end
        mss_pkg::OFF_SAFE_LO: begin
          if ($signed(wd) > s.safe_hi) set_f[mss_pkg::ST_OVERLAP] = 1'b1;
          else next_s.safe_lo = wd;
        end
        mss_pkg::OFF_SAFE_HI: begin
          if ($signed(wd) < s.safe_lo) set_f[mss_pkg::ST_OVERLAP] = 1'b1;
          else next_s.safe_hi = wd;
        end
        mss_pkg::OFF_VLIM: next_s.vlim = wd;
        mss_pkg::OFF_DWELL: begin
          if (wd[7:0] < mss_pkg::DWELL_MIN) set_f[mss_pkg::ST_DWELL] = 1'b1;
          else next_s.dwell = wd[7:0];
        end
        mss_pkg::OFF_INDUCT: begin
          if (wd > mss_pkg::INDUCT_MAX) set_f[mss_pkg::ST_RANGE] = 1'b1;
          else next_s.induct = wd;
        end
        mss_pkg::OFF_HTR_I: begin
          if (wd > mss_pkg::HTR_I_MAX) set_f[mss_pkg::ST_RANGE] = 1'b1;
          else next_s.htr_i = wd;
        end
        mss_pkg::OFF_AMPS, mss_pkg::OFF_TESLA: begin
          if (a == mss_pkg::OFF_AMPS) next_s.amps = wd;
          else next_s.tesla = wd;
          next_s.div_cnt = 6'd32;
          next_s.div_q = (a == mss_pkg::OFF_TESLA) ? {wd, 16'h0000}
                                                   : {s.tesla, 16'h0000};
          next_s.div_rem = 17'h0_0000;
        end
        mss_pkg::OFF_CTRL: next_s.ctrl = pwdata[3:0];
        default: begin
          if (a >= mss_pkg::OFF_BKPT && a < 12'h080) begin
            if (a[5:2] != 4'h0 && a[5:2] != 4'hF) begin
              next_s.bkpt[a[5:2]] = wd;
            end
          end else if (a >= mss_pkg::OFF_RATE && a < 12'h200) begin
            next_s.rate[a[7:6]][a[5:2]] = wd;
          end
        end
      endcase
    end

    // Sticky error flags: write one to clear, new event wins
    next_s.flags = s.flags & ~((wr && a == mss_pkg::OFF_STAT) ? pwdata[4:0]
                                                               : 5'h00);
    next_s.flags = next_s.flags | set_f;

    // Field constant: tesla * 2^16 / amps, one bit per cycle
    if (s.div_cnt != 6'd0 && !(wr && (a == mss_pkg::OFF_AMPS
                                      || a == mss_pkg::OFF_TESLA))) begin
      rs = {s.div_rem[15:0], s.div_q[31]};
      next_s.div_q = {s.div_q[30:0], 1'b0};
      if (s.amps != 16'h0000 && rs >= {1'b0, s.amps}) begin
        rs = 17'(rs - {1'b0, s.amps});
        next_s.div_q[0] = 1'b1;
      end
      next_s.div_rem = rs;
      next_s.div_cnt = 6'(s.div_cnt - 6'd1);
      if (s.div_cnt == 6'd1) begin
        next_s.k = (s.amps == 16'h0000) ? 24'h00_0000 : next_s.div_q[23:0];
      end
    end
    fp = meas_current * $signed({1'b0, s.k});
    next_s.field = fp[31:16];

    // Heater follows request or edit only with a switch fitted
    next_s.heater = s.cfg[mss_pkg::CFG_SWITCH]
                    && (s.ctrl[mss_pkg::CTRL_HREQ]
                        || s.ctrl[mss_pkg::CTRL_HEDIT]);
    next_s.htr_out = next_s.heater ? next_s.htr_i : 16'h0000;

    // Safe window
    next_s.safe = (meas_current >= s.safe_lo)
                  && (meas_current <= s.safe_hi);

    // Segment n: first breakpoint at or above the present current
    for (int n = 15; n >= 1; n--) begin
      if (am <= {1'b0, s.bkpt[n]}) seg = 4'(n);
    end
    if (s.cfg[mss_pkg::CFG_SWITCH] && !s.heater) begin
      tsel = s.af_s2 ? mss_pkg::TBL_LEAD_FIELD : mss_pkg::TBL_LEAD_ZERO;
    end else begin
      tsel = s.ctrl[mss_pkg::CTRL_FAST] ? mss_pkg::TBL_FAST
                                        : mss_pkg::TBL_SLOW;
    end
    next_s.rate_out = s.rate[tsel][seg];

    // Filter charge current on each change of sweep slope
    rate_eff = s.ctrl[mss_pkg::CTRL_SWEEP] ? s.rate_out : 16'h0000;
    lrate = $signed({1'b0, s.induct}) * $signed({1'b0, rate_eff});
    next_s.lrate_prev = lrate;
    next_s.cmp_pre = (s.cmp_pre == QTR_LAST) ? 26'h000_0000
                                             : 26'(s.cmp_pre + 26'h1);
    if (lrate != s.lrate_prev) begin
      dl = 33'(lrate - s.lrate_prev);
      next_s.comp = 16'(dl >>> mss_pkg::COMP_SHIFT);
      next_s.cmp_pre = 26'h000_0000;
    end else if (s.cmp_pre == QTR_LAST) begin
      next_s.comp = 16'sh0000;
    end
    cmd_w = s.setp + (s.cfg[mss_pkg::CFG_FILTER] ? s.comp : 16'sh0000);
    if (s.cfg[mss_pkg::CFG_UNIPOL] && cmd_w < 0) cmd_w = 17'sh0_0000;
    if (cmd_w > 17'sh0_7FFF) cmd_w = 17'sh0_7FFF;
    if (cmd_w < -17'sh0_8000) cmd_w = -17'sh0_8000;
    next_s.cmd = cmd_w[15:0];

    // Software voltage limit, same magnitude both ways
    sw_over = mss_abs(out_voltage) > {1'b0, s.vlim};
    if (sw_over) begin
      next_s.sw_pre = (s.sw_pre == QTR_LAST) ? 26'h000_0000
                                             : 26'(s.sw_pre + 26'h1);
      if (s.sw_pre == QTR_LAST && s.sw_qtr != 8'hFF) begin
        next_s.sw_qtr = 8'(s.sw_qtr + 8'h1);
      end
    end else begin
      next_s.sw_pre = 26'h000_0000;
      next_s.sw_qtr = 8'h00;
    end

    // Hardware limit blanking in quarter seconds
    if (s.hw_s2) begin
      next_s.hw_pre = (s.hw_pre == QTR_LAST) ? 26'h000_0000
                                             : 26'(s.hw_pre + 26'h1);
      if (s.hw_pre == QTR_LAST && s.hw_qtr != mss_pkg::BLANK_QTRS) begin
        next_s.hw_qtr = 4'(s.hw_qtr + 4'h1);
      end
    end else begin
      next_s.hw_pre = 26'h000_0000;
      next_s.hw_qtr = 4'h0;
    end

    // Catch mode: trip sets, software clear yields to a trip
    if (wr && a == mss_pkg::OFF_CTRL && pwdata[mss_pkg::CTRL_CCLR]) begin
      next_s.catch = 1'b0;
    end
    if (sw_over && s.dwell != mss_pkg::DWELL_OFF
        && s.sw_qtr >= s.dwell) begin
      next_s.catch = 1'b1;
    end
    if (s.hw_s2 && (!s.cfg[mss_pkg::CFG_BLANK]
                    || s.hw_qtr == mss_pkg::BLANK_QTRS)) begin
      next_s.catch = 1'b1;
    end

    // Read data
    if (rd) begin
      next_s.prdata = 32'h0000_0000;
      unique case (a)
        mss_pkg::OFF_CFG:     next_s.prdata[7:0] = s.cfg;
        mss_pkg::OFF_ILIM:    next_s.prdata[15:0] = s.ilim;
        mss_pkg::OFF_SETP:    next_s.prdata[15:0] = s.setp;
        mss_pkg::OFF_SAFE_LO: next_s.prdata[15:0] = s.safe_lo;
        mss_pkg::OFF_SAFE_HI: next_s.prdata[15:0] = s.safe_hi;
        mss_pkg::OFF_VLIM:    next_s.prdata[15:0] = s.vlim;
        mss_pkg::OFF_DWELL:   next_s.prdata[7:0] = s.dwell;
        mss_pkg::OFF_INDUCT:  next_s.prdata[15:0] = s.induct;
        mss_pkg::OFF_HTR_I:   next_s.prdata[15:0] = s.htr_i;
        mss_pkg::OFF_AMPS:    next_s.prdata[15:0] = s.amps;
        mss_pkg::OFF_TESLA:   next_s.prdata[15:0] = s.tesla;
        mss_pkg::OFF_CTRL:    next_s.prdata[3:0] = s.ctrl;
        mss_pkg::OFF_STAT: begin
          next_s.prdata[4:0] = s.flags;
          next_s.prdata[mss_pkg::ST_SAFE] = s.safe;
          next_s.prdata[mss_pkg::ST_CATCH] = s.catch;
          next_s.prdata[mss_pkg::ST_HEATER] = s.heater;
          next_s.prdata[mss_pkg::ST_HWLIM] = s.hw_s2;
        end
        mss_pkg::OFF_CMD:     next_s.prdata[15:0] = s.cmd;
        mss_pkg::OFF_FIELD:   next_s.prdata[15:0] = s.field;
        default: begin
          if (a >= mss_pkg::OFF_BKPT && a < 12'h080) begin
            next_s.prdata[15:0] = s.bkpt[a[5:2]];
          end else if (a >= mss_pkg::OFF_RATE && a < 12'h200) begin
            next_s.prdata[15:0] = s.rate[a[7:6]][a[5:2]];
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s           <= '0;
      s.cfg       <= mss_pkg::CFG_RESET;
      s.ilim      <= mss_pkg::FULL_SCALE;
      s.safe_lo   <= -$signed(mss_pkg::FULL_SCALE);
      s.safe_hi   <= mss_pkg::FULL_SCALE;
      s.vlim      <= HIGH_V ? mss_pkg::VLIM_20V : mss_pkg::VLIM_10V;
      s.dwell     <= mss_pkg::DWELL_OFF;
      s.bkpt[15]  <= mss_pkg::FULL_SCALE;
    end else begin
      s <= next_s;
    end
  end

  assign pready                         = s.pready;
  assign pslverr                        = s.pslverr;
  assign prdata                         = s.prdata;
  assign cmd_current                    = s.cmd;
  assign rate_limit                     = s.rate_out;
  assign safe_current                   = s.safe;
  assign catch_mode                     = s.catch;
  assign heater_on                      = s.heater;
  assign heater_current                 = s.htr_out;
  assign config_reject_indication       = s.flags[mss_pkg::ST_CFG_REJ];
  assign safe_window_overlap_indication = s.flags[mss_pkg::ST_OVERLAP];

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic apb_wr;
  assign apb_wr = psel && penable && pready && pwrite;

  a_cfg_reject_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == mss_pkg::OFF_CFG && pwdata[0] && pwdata[1]
    |=> s.cfg == $past(s.cfg) && config_reject_indication)
    else $error("illegal configuration was accepted");

  a_heater_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    heater_on |-> $past(s.cfg[mss_pkg::CFG_SWITCH]))
    else $error("heater on without switch fitted");

  a_unipolar_cmd: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(s.cfg[mss_pkg::CFG_UNIPOL]) |-> !cmd_current[15])
    else $error("negative current in unipolar mode");

  a_setp_refused: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == mss_pkg::OFF_SETP
    && mss_abs(pwdata[15:0]) > {1'b0, s.ilim}
    |=> s.setp == $past(s.setp) && s.flags[mss_pkg::ST_SETP_REJ])
    else $error("set-point above limit accepted");

  a_safe_window: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(presetn)
    |-> safe_current == ($past(meas_current) >= $past(s.safe_lo)
                         && $past(meas_current) <= $past(s.safe_hi)))
    else $error("safe output disagrees with window");

  a_overlap_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == mss_pkg::OFF_SAFE_LO
    && $signed(pwdata[15:0]) > s.safe_hi
    |=> safe_window_overlap_indication && $stable(s.safe_lo))
    else $error("overlapping safe window accepted");

  a_bkpt_fixed: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.bkpt[0] == 16'h0000 && s.bkpt[15] == mss_pkg::FULL_SCALE)
    else $error("fixed breakpoint changed");

  a_dwell_min: assert property (
    @(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == mss_pkg::OFF_DWELL && pwdata[7:0] < 8'h02
    |=> s.flags[mss_pkg::ST_DWELL] && $stable(s.dwell))
    else $error("dwell below two accepted");

  a_hw_immediate: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.hw_s2 && !s.cfg[mss_pkg::CFG_BLANK] |=> catch_mode)
    else $error("hardware limit did not trip at once");

  a_hw_blanked: assert property (
    @(posedge pclk) disable iff (!presetn)
    s.cfg[mss_pkg::CFG_BLANK] && s.hw_qtr == 4'h0 && !catch_mode
    && mss_abs(out_voltage) <= {1'b0, s.vlim}
    |=> !catch_mode)
    else $error("blanked hardware limit tripped early");

endmodule // mss_supervisor

`default_nettype wire

// File: tb/mss_magnet_model.sv
// Magnet load model: follows the operator targets one cycle late
`timescale 1ns/1ns
`default_nettype none
module mss_magnet_model (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Operator targets
  input  wire logic signed [15:0] i_tgt,
  input  wire logic signed [15:0] v_tgt,
  input  wire logic               lim_tgt,
  // Load outputs
  output logic signed [15:0]      meas_current,
  output logic signed [15:0]      out_voltage,
  output logic                    hw_vlimit,
  output logic                    magnet_at_field
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_current    <= '0;
      out_voltage     <= '0;
      hw_vlimit       <= 1'b0;
      magnet_at_field <= 1'b0;
    end else begin
      meas_current    <= i_tgt;
      out_voltage     <= v_tgt;
      hw_vlimit       <= lim_tgt;
      magnet_at_field <= (i_tgt != 16'sh0000);
    end
  end
endmodule // mss_magnet_model
`default_nettype wire

// File: tb/test_magnet_sweep_supervisor.sv
// Self-checking bench for the magnet sweep supervisor
`timescale 1ns/1ns
`default_nettype none
module test_magnet_sweep_supervisor;
  logic               pclk, presetn, psel, penable, pwrite, last_err, bad;
  logic               pready, pslverr, hw_vlimit, magnet_at_field, lim_tgt;
  logic               safe_current, catch_mode, heater_on;
  logic               config_reject_indication, safe_window_overlap_indication;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, v32;
  logic signed [15:0] meas_current, out_voltage, i_tgt, v_tgt;
  logic signed [15:0] cmd_current;
  logic [15:0]        rate_limit, heater_current;
  logic [7:0]         v, prev;
  integer             seed;
  int                 error_cnt, check_count, i;

  always #2 pclk = ~pclk;

  mss_supervisor #(.QTR_CYC(10)) DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .meas_current,
    .out_voltage, .hw_vlimit, .magnet_at_field, .cmd_current,
    .rate_limit, .safe_current, .catch_mode, .heater_on,
    .heater_current, .config_reject_indication,
    .safe_window_overlap_indication);
  mss_magnet_model u_load (.pclk, .presetn, .i_tgt, .v_tgt, .lim_tgt,
    .meas_current, .out_voltage, .hw_vlimit, .magnet_at_field);

  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin error_cnt++; complete_run(); end
    v32 = prdata; last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000); chk(v32, e);
  endtask

  // Bounded wait for catch (0), heater (1) or safe (2) to reach a level
  task automatic wait_for(input int sel, input logic e);
    int n; logic s;
    for (n = 0; n < 200; n++) begin
      case (sel) 0: s = catch_mode; 1: s = heater_on; default: s = safe_current; endcase
      if (s === e) break;
      @(posedge pclk);
    end
    chk({31'h0, s}, {31'h0, e});
    if (n >= 200) complete_run();
  endtask

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
    pwdata = '0; i_tgt = '0; v_tgt = '0; lim_tgt = 0; seed = 32'hae21;
    prev = 8'h00; error_cnt = 0; check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(mss_pkg::OFF_VLIM, 32'h0000_04E1);
    rc(mss_pkg::OFF_DWELL, 32'h0000_00FF);
    rc(mss_pkg::OFF_INDUCT, 32'h0000_0000);
    rc(mss_pkg::OFF_HTR_I, 32'h0000_0000);
    for (i = 0; i < 12; i++) begin
      v = (i == 0) ? 8'h03 : 8'($random(seed));
      bad = (v[1:0] == 2'b11);
      wr(mss_pkg::OFF_CFG, {24'h0, v});
      if (!bad) prev = v;
      rc(mss_pkg::OFF_CFG, {24'h0, prev});
      chk({31'h0, config_reject_indication}, {31'h0, bad});
      if (bad) wr(mss_pkg::OFF_STAT, 32'h0000_0001);
    end
    apb(1'b0, 12'h03C, 32'h0000_0000);
    chk({31'h0, last_err}, 32'h0000_0001);
    wr(mss_pkg::OFF_CFG, 32'h0000_0000);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0001);
    wait_for(1, 1'b0);
    wr(mss_pkg::OFF_CFG, 32'h0000_0001);
    wait_for(1, 1'b1);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0000);
    wait_for(1, 1'b0);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0002);
    wait_for(1, 1'b1);
    wr(mss_pkg::OFF_HTR_I, 32'h0000_04A7);
    @(posedge pclk);
    chk({16'h0, heater_current}, 32'h0000_04A7);
    wr(mss_pkg::OFF_SETP, 32'h0000_2EE1);
    rc(mss_pkg::OFF_STAT, 32'h0000_0502);
    wr(mss_pkg::OFF_DWELL, 32'h0000_0001);
    rc(mss_pkg::OFF_DWELL, 32'h0000_00FF);
    rc(mss_pkg::OFF_STAT, 32'h0000_050A);
    wr(mss_pkg::OFF_SAFE_LO, 32'h0000_2EE1);
    rc(mss_pkg::OFF_STAT, 32'h0000_050E);
    chk({31'h0, safe_window_overlap_indication}, 32'h0000_0001);
    wr(mss_pkg::OFF_BKPT, 32'h0000_0100);
    rc(mss_pkg::OFF_BKPT, 32'h0000_0000);
    wr(mss_pkg::OFF_BKPT + 12'h03C, 32'h0000_0005);
    rc(mss_pkg::OFF_BKPT + 12'h03C, 32'h0000_2EE0);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0000);
    wr(mss_pkg::OFF_STAT, 32'h0000_001F);
    wr(mss_pkg::OFF_CFG, 32'h0000_0008);
    wr(mss_pkg::OFF_SETP, 32'h0000_FFFB);
    rc(mss_pkg::OFF_STAT, 32'h0000_0102);
    i_tgt <= 16'sh3000;
    wait_for(2, 1'b0);
    i_tgt <= 16'sh0100;
    wait_for(2, 1'b1);
    wr(mss_pkg::OFF_SETP, 32'h0000_0100);
    wr(mss_pkg::OFF_INDUCT, 32'h0000_0100);
    wr(mss_pkg::OFF_RATE + 12'h0FC, 32'h0000_0100);
    wr(mss_pkg::OFF_CFG, 32'h0000_0002);
    chk({16'h0, rate_limit}, 32'h0000_0100);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0008);
    repeat (3) @(posedge pclk);
    chk({16'h0, cmd_current}, 32'h0000_0101);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk({16'h0, cmd_current}, 32'h0000_00FF);
    wr(mss_pkg::OFF_AMPS, 32'h0000_0100);
    wr(mss_pkg::OFF_TESLA, 32'h0000_0080);
    repeat (40) @(posedge pclk);
    rc(mss_pkg::OFF_FIELD, 32'h0000_0080);
    wr(mss_pkg::OFF_CFG, 32'h0000_0000);
    lim_tgt <= 1'b1;
    wait_for(0, 1'b1);
    lim_tgt <= 1'b0;
    wr(mss_pkg::OFF_CTRL, 32'h0000_0010);
    wait_for(0, 1'b0);
    wr(mss_pkg::OFF_CFG, 32'h0000_0004);
    lim_tgt <= 1'b1;
    repeat (60) @(posedge pclk);
    chk({31'h0, catch_mode}, 32'h0000_0000);
    wait_for(0, 1'b1);
    lim_tgt <= 1'b0;
    wr(mss_pkg::OFF_CTRL, 32'h0000_0010);
    wait_for(0, 1'b0);
    wr(mss_pkg::OFF_DWELL, 32'h0000_0002);
    v_tgt <= -16'sh0600;
    wait_for(0, 1'b1);
    wr(mss_pkg::OFF_DWELL, 32'h0000_00FF);
    wr(mss_pkg::OFF_CTRL, 32'h0000_0010);
    repeat (100) @(posedge pclk);
    chk({31'h0, catch_mode}, 32'h0000_0000);
    complete_run();
  end
endmodule // test_magnet_sweep_supervisor
`default_nettype wire
